// ---- common/acc_pkg.sv ----
// Contract
// RULE_01: With flag-clear enable set in break, clears work and persist after break.
// RULE_02: With flag-clear enable zero in break, accesses leave status flags unchanged.
// RULE_03: A two-step clear begun before a protected break completes after it; the code releases the result lock on any low read, even in the break.
// RULE_04: No hardware trigger; conversions start only by control register writes.
// RULE_05: Every control write aborts and restarts, unless channel code is all ones.
// RULE_06: Done flag is read-only and set by hardware at each conversion end.
// RULE_07: Done flag clears on control write or low result byte read.
// RULE_08: Interrupt enable one raises a request at each conversion end.
// RULE_09: Pending request clears on result read or control write.
// RULE_10: Continuous bit with valid channel runs back-to-back conversions, updating results.
// RULE_11: Continuous stops on reset, stop without async clock, clock write, control write.
// RULE_12: After stop halt, only a fresh control write restarts conversions.
// RULE_13: Control write with continuous and valid channel aborts and starts continuous.
// RULE_14: Software keeps bus clock fast enough relative to converter clock.
// RULE_15: Continuous clear: each valid control write produces exactly one conversion.
// RULE_16: Channel field five bits: 0-5 inputs, 26 bandgap, 29 high, 30 low ref.
// RULE_17: All-ones channel powers off, isolates input, no extra single conversion.
// RULE_18: Converter enters low power by itself after each completed conversion; the code keeps power on between conversions in continuous mode.
// RULE_19: Done flag sets at every conversion end regardless of interrupt enable.
// RULE_20: In 10-bit mode high byte read blocks results until low byte read.
// RULE_21: Unused or reserved channel still converts; its value is undefined.
// RULE_22: Async clock enable one keeps conversions going in stop mode.
// RULE_23: Interrupt request is a level held until a clearing action.
package acc_pkg;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RES_HI = 3'h1;
  localparam logic [2:0] ADDR_RES_LO = 3'h2;
  localparam logic [2:0] ADDR_CLK = 3'h3;
  localparam logic [2:0] ADDR_BRK = 3'h4;
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_IEN_BIT = 6;
  localparam int CTRL_CONT_BIT = 5;
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam logic [4:0] CHAN_LAST_EXT = 5'h05;
  localparam logic [4:0] CHAN_BANDGAP = 5'h1a;
  localparam logic [4:0] CHAN_REF_HI = 5'h1d;
  localparam logic [4:0] CHAN_REF_LO = 5'h1e;
  localparam logic [7:0] CTRL_RESET = 8'h1f;
  localparam logic [7:0] CLK_RESET = 8'h00;
  localparam int CLK_MODE10_BIT = 2;
  localparam int BRK_CLEAR_EN_BIT = 7;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acc_bus_t;
endpackage

// ---- core/acc_conv_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire acc_pkg::acc_bus_t bus,
  output logic [7:0] rdata,
  input wire logic break_active,
  input wire logic stop_mode,
  output logic conv_start,
  output logic conv_abort,
  output logic conv_power_on,
  output logic [4:0] channel_select,
  input wire logic conv_finish,
  input wire logic [9:0] conv_value,
  output logic irq
);
  typedef enum logic [1:0] {ACC_IDLE, ACC_BUSY} acc_state_t;
  acc_state_t state_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] clk_reg;
  logic brk_reg;
  logic done_reg;
  logic irq_reg;
  logic lock_reg;
  logic [9:0] result_reg;
  logic ctrl_wr;
  logic clk_wr;
  logic hi_rd;
  logic lo_rd;
  logic clear_ok;
  logic chan_on;
  logic halt;
  // Decode; flag side effects suppressed in a protected break
  always_comb
  begin
    ctrl_wr = bus.wr && bus.addr == acc_pkg::ADDR_CTRL;
    clk_wr = bus.wr && bus.addr == acc_pkg::ADDR_CLK;
    hi_rd = bus.rd && bus.addr == acc_pkg::ADDR_RES_HI;
    lo_rd = bus.rd && bus.addr == acc_pkg::ADDR_RES_LO;
    clear_ok = !break_active || brk_reg; // RULE_01 RULE_02
    chan_on = bus.wdata[4:0] != acc_pkg::CHAN_OFF; // RULE_17
    // Stop without async clock kills work; async clock keeps running
    halt = stop_mode && !clk_reg[acc_pkg::CLK_MODE10_BIT + 4]; // RULE_11 RULE_22
  end
  // Control register; done bit lives separately
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_reg <= acc_pkg::CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= {1'b0, bus.wdata[6:0]}; // RULE_06
  end
  // Clock register; bit 6 used as async clock enable
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      clk_reg <= acc_pkg::CLK_RESET;
    else if (clk_wr)
      clk_reg <= bus.wdata;
  end
  // Break flag-clear enable, default zero
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      brk_reg <= 1'b0;
    else if (bus.wr && bus.addr == acc_pkg::ADDR_BRK)
      brk_reg <= bus.wdata[acc_pkg::BRK_CLEAR_EN_BIT];
  end
  // Sequencer: software-only start, abort on every control write
  // No trigger input exists, so only the register path starts work
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= ACC_IDLE;
    else if (ctrl_wr)
      state_reg <= chan_on ? ACC_BUSY : ACC_IDLE; // RULE_04 RULE_05 RULE_17
    else if (halt || clk_wr)
      state_reg <= ACC_IDLE; // RULE_11 RULE_12
    else
    begin
      case (state_reg)
        ACC_BUSY:
          if (conv_finish && !ctrl_reg[acc_pkg::CTRL_CONT_BIT])
            state_reg <= ACC_IDLE; // RULE_15 RULE_18
        default:
          state_reg <= ACC_IDLE;
      endcase
    end
  end
  // Start pulse on a control write unless channel is all ones, and again after each finish in continuous mode
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end
    else
    begin
      conv_abort <= ctrl_wr || halt || clk_wr; // RULE_05
      // A control write in the finish cycle overrides the chained start
      conv_start <= (ctrl_wr && chan_on) // RULE_13 RULE_21
        || (state_reg == ACC_BUSY && conv_finish && !halt && !clk_wr
        && !ctrl_wr && ctrl_reg[acc_pkg::CTRL_CONT_BIT]); // RULE_10 RULE_17
    end
  end
  assign conv_power_on = state_reg == ACC_BUSY; // RULE_18
  assign channel_select = ctrl_reg[4:0]; // RULE_16
  // Done flag: set wins over clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      done_reg <= 1'b0;
    else if (state_reg == ACC_BUSY && conv_finish)
      done_reg <= 1'b1; // RULE_06 RULE_19
    else if ((ctrl_wr || lo_rd) && clear_ok)
      done_reg <= 1'b0; // RULE_07 RULE_01 RULE_02
  end
  // Interrupt level held until cleared
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_reg <= 1'b0;
    else if (state_reg == ACC_BUSY && conv_finish
      && ctrl_reg[acc_pkg::CTRL_IEN_BIT])
      irq_reg <= 1'b1; // RULE_08 RULE_23
    else if ((ctrl_wr || lo_rd || hi_rd) && clear_ok)
      irq_reg <= 1'b0; // RULE_09
  end
  assign irq = irq_reg;
  // High read in 10-bit mode locks results; any low read releases the lock, even in a protected break
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      lock_reg <= 1'b0;
    else if (lo_rd)
      lock_reg <= 1'b0; // RULE_03
    else if (hi_rd && clk_reg[acc_pkg::CLK_MODE10_BIT])
      lock_reg <= 1'b1; // RULE_20
  end
  // Result capture; finishes while locked are dropped
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      result_reg <= 10'h000;
    else if (state_reg == ACC_BUSY && conv_finish && !lock_reg)
      result_reg <= conv_value; // RULE_10 RULE_20
  end
  // Read data one cycle after strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      if (bus.addr == acc_pkg::ADDR_CTRL)
        rdata <= {done_reg, ctrl_reg[6:0]};
      else if (bus.addr == acc_pkg::ADDR_RES_HI)
        rdata <= {6'h00, result_reg[9:8]};
      else if (bus.addr == acc_pkg::ADDR_RES_LO)
        rdata <= result_reg[7:0];
      else if (bus.addr == acc_pkg::ADDR_CLK)
        rdata <= clk_reg;
      else if (bus.addr == acc_pkg::ADDR_BRK)
        rdata <= {brk_reg, 7'h00};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// ---- verification/acc_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module acc_props
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire acc_pkg::acc_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic break_active,
  input wire logic stop_mode,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_power_on,
  input wire logic [4:0] channel_select,
  input wire logic conv_finish,
  input wire logic [9:0] conv_value,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Control write, and one whose channel is not the off code
  sequence s_cw;
    bus.wr && bus.addr == 3'h0;
  endsequence
  sequence s_on;
    s_cw ##0 bus.wdata[4:0] != 5'h1f;
  endsequence
  AST_RESTART: assert property (s_on |=> conv_start && conv_abort)
    else $error("no restart");
  AST_OFF: assert property
    (s_cw ##0 &bus.wdata[4:0] |=> !conv_start && !conv_power_on)
    else $error("off code started");
  AST_CHAN: assert property
    (s_cw |=> channel_select == $past(bus.wdata[4:0]))
    else $error("channel not taken");
  // Only software or a continuous chain may start the core
  AST_SWONLY: assert property
    (conv_start |-> $past(bus.wr) || $past(conv_finish))
    else $error("start without cause");
  AST_HOLD: assert property (irq && !bus.wr && !bus.rd |=> irq)
    else $error("irq dropped");
  AST_CAUSE: assert property ($rose(irq) |-> $past(conv_finish))
    else $error("irq without end");
  AST_CLR: assert property
    (s_cw ##0 !break_active && !conv_finish |=> !irq)
    else $error("irq kept");
  AST_PWR: assert property (conv_start |-> conv_power_on)
    else $error("start while off");
endmodule
bind acc_conv_ctrl acc_props u_props (.*);
`default_nettype wire

// ---- verification/adc_conversion_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_test;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  acc_pkg::acc_bus_t bus = '0;
  logic break_active = 1'b0;
  logic stop_mode = 1'b0;
  logic conv_finish = 1'b0;
  logic [9:0] conv_value = 10'h000;
  logic [7:0] rdata;
  logic [4:0] channel_select;
  logic conv_start, conv_abort, conv_power_on, irq;
  int err_count = 0;
  int checks = 0;
  acc_conv_ctrl dut (.*);
  // 40 MHz
  always #12.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle strobes; an edge passes before the next strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    @(negedge sys_clk) chk(rdata, e);
  endtask
  // Core reports an end of conversion with a result
  task automatic fin(input logic [9:0] v);
    @(posedge sys_clk) conv_finish <= 1'b1;
    conv_value <= v;
    @(posedge sys_clk) conv_finish <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic brk(input logic b);
    @(posedge sys_clk) break_active <= b;
  endtask
  task automatic give_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Guards against a hang; tests need well under 1000 cycles
  initial
  begin
    #50us;
    err_count++;
    give_verdict;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(3'h0, 8'h1f);
    rd(3'h7, 8'h00);
    wr(3'h0, 8'h45);
    fin(10'h2a5);
    chk(irq, 1'b1);
    rd(3'h0, 8'hc5);
    chk(conv_power_on, 1'b0);
    rd(3'h2, 8'ha5);
    rd(3'h0, 8'h45);
    chk(irq, 1'b0);
    wr(3'h0, 8'h03);
    fin(10'h000);
    chk(irq, 1'b0);
    rd(3'h0, 8'h83);
    wr(3'h0, 8'h1f);
    rd(3'h0, 8'h1f);
    $display("single end");
    wr(3'h0, 8'h21);
    fin(10'h001);
    fin(10'h002);
    chk(conv_power_on, 1'b1);
    rd(3'h2, 8'h02);
    wr(3'h3, 8'h00);
    fin(10'h003);
    chk(conv_power_on, 1'b0);
    wr(3'h0, 8'h21);
    @(posedge sys_clk) stop_mode <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(conv_power_on, 1'b0);
    @(posedge sys_clk) stop_mode <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(conv_power_on, 1'b0);
    $display("continuous end");
    wr(3'h0, 8'h43);
    fin(10'h005);
    brk(1'b1);
    rd(3'h2, 8'h05);
    rd(3'h0, 8'hc3);
    chk(irq, 1'b1);
    brk(1'b0);
    wr(3'h4, 8'h80);
    brk(1'b1);
    rd(3'h2, 8'h05);
    chk(irq, 1'b0);
    brk(1'b0);
    rd(3'h0, 8'h43);
    $display("break end");
    wr(3'h3, 8'h04);
    wr(3'h0, 8'h01);
    fin(10'h3c7);
    rd(3'h1, 8'h03);
    wr(3'h0, 8'h01);
    fin(10'h155);
    rd(3'h2, 8'hc7);
    $display("lock end");
    wr(3'h3, 8'h44);
    wr(3'h0, 8'h21);
    @(posedge sys_clk) stop_mode <= 1'b1;
    fin(10'h0aa);
    chk(conv_power_on, 1'b1);
    @(posedge sys_clk) stop_mode <= 1'b0;
    rd(3'h2, 8'haa);
    wr(3'h0, 8'h1f);
    @(negedge sys_clk) chk(conv_power_on, 1'b0);
    $display("async end");
    give_verdict;
  end
endmodule
`default_nettype wire
